/* File: shared/pacl_pkg.sv */
// Package holding the timing constants and default values of the accelerometer pulse loop.
package pacl_pkg;
  // System clock period in picoseconds (125 MHz).
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Strobe repetition rate in pulses per second.
  localparam int unsigned STROBE_RATE_PPS = 3200;
  // Strobe timing in nanoseconds.
  localparam int unsigned SAMPLE_WIDTH_NS = 2000;
  localparam int unsigned SELECT_DELAY_NS = 3000;
  localparam int unsigned SELECT_WIDTH_NS = 3000;
  localparam int unsigned DATA_DELAY_NS = 2000;
  localparam int unsigned DATA_WIDTH_NS = 3000;
  // Strobe period in nanoseconds.
  localparam int unsigned STROBE_PERIOD_NS = 1000000000 / STROBE_RATE_PPS;
  // Cycle counts derived from the times; widths round up, the period rounds down.
  localparam int unsigned SAMPLE_WIDTH_CYC = (SAMPLE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SELECT_DELAY_CYC = (SELECT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SELECT_WIDTH_CYC = (SELECT_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DATA_DELAY_CYC = (DATA_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DATA_WIDTH_CYC = (DATA_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_PERIOD_CYC = (STROBE_PERIOD_NS * 1000) / CLK_PERIOD_PS;
  // Reset value of both flip-flops: plus state drives the float toward null.
  localparam logic DIR_RESET = 1'b1;
  // Default capacity of the up-down velocity counter.
  localparam int unsigned COUNT_CAPACITY = 4;
endpackage : pacl_pkg

/* File: shared/pacl_if.sv */
// Interface joining the loop electronics and the computer-side strobe source.
`timescale 1ns/1ps
`default_nettype none
interface pacl_if;
  logic float_sample_strobe;
  logic select_strobe;
  logic data_strobe;
  logic vel_plus_pulse;
  logic vel_minus_pulse;
  modport loop_end (
    input float_sample_strobe, select_strobe, data_strobe,
    output vel_plus_pulse, vel_minus_pulse
  );
  modport computer_end (
    output float_sample_strobe, select_strobe, data_strobe,
    input vel_plus_pulse, vel_minus_pulse
  );
endinterface : pacl_if
`default_nettype wire

/* File: verilog/pacl_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pacl_sync3 (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out
);
  logic [2:0] stage;

  // Stage 0 is read only by stage 1, so metastability never reaches logic.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[1:0], async_in};
    end
  end

  // The output follows only when the two settled stages agree.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      level_out <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_out <= stage[2];
    end
  end
endmodule : pacl_sync3
`default_nettype wire

/* File: verilog/pacl_loop.sv */
// Loop end: interrogator, winding selection flip-flop and velocity pulse gating.
// Summary of operation
// - Computer sends 2 us sample strobe, 3200/s.
// - Strobe gates zero/pi phase into set/reset.
// - Direction goes plus on set, minus on reset.
// - Select strobe 3 us, 3 us after sample.
// - Each select strobe pulses exactly one select.
// - Winding flip-flop follows plus/minus select pulses.
// - Exactly one torque switch enabled at once.
// - Data strobe 3 us, 2 us after select.
// - Data strobe emits exactly one velocity pulse.
// - At zero acceleration loop runs three and three.
// - Counter counts up plus, down minus.
// - Counter overflow emits a velocity increment.
// - Winding may reverse on every select strobe.
// - Excitation is derived from the computer clock.
// - Reset forces a defined winding selection.
// - Direction changes only during a sample strobe.
`timescale 1ns/1ps
`default_nettype none
module pacl_loop
  import pacl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  pacl_if.loop_end link,
  input wire logic zero_phase_in,
  input wire logic pi_phase_in,
  output logic plus_select_pulse_out,
  output logic minus_select_pulse_out,
  output logic torque_plus_en_out,
  output logic torque_minus_en_out,
  output logic float_dir_out
);
  logic zero_phase;
  logic pi_phase;
  logic set_pulse;
  logic reset_pulse;
  logic float_dir;
  logic winding_plus;

  // Phase detectors come from the analog side, so they pass the synchroniser.
  pacl_sync3 u_sync_zero (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(zero_phase_in),
    .level_out(zero_phase)
  );
  pacl_sync3 u_sync_pi (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(pi_phase_in),
    .level_out(pi_phase)
  );

  // Sample strobe gates each phase; both active at once is treated as no change.
  assign set_pulse = link.float_sample_strobe & zero_phase & ~pi_phase;
  assign reset_pulse = link.float_sample_strobe & pi_phase & ~zero_phase;

  // Direction flip-flop; it only moves under the strobe, never between strobes.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      float_dir <= DIR_RESET;
    end else if (set_pulse) begin
      float_dir <= 1'b1;
    end else if (reset_pulse) begin
      float_dir <= 1'b0;
    end
  end

  // Select strobe steers exactly one of the two select pulses.
  assign plus_select_pulse_out = link.select_strobe & float_dir;
  assign minus_select_pulse_out = link.select_strobe & ~float_dir;

  // Winding flip-flop can reverse on every select strobe, giving the 1600 cps limit.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      winding_plus <= DIR_RESET;
    end else if (plus_select_pulse_out) begin
      winding_plus <= 1'b1;
    end else if (minus_select_pulse_out) begin
      winding_plus <= 1'b0;
    end
  end

  // One register and its inverse keep both switches from ever conducting together.
  assign torque_plus_en_out = winding_plus;
  assign torque_minus_en_out = ~winding_plus;
  assign float_dir_out = float_dir;

  // Data strobe gates the winding state into one velocity pulse per period.
  assign link.vel_plus_pulse = link.data_strobe & winding_plus;
  assign link.vel_minus_pulse = link.data_strobe & ~winding_plus;
endmodule : pacl_loop
`default_nettype wire

/* File: verilog/pacl_computer.sv */
// Computer end: strobe timing generator and up-down velocity counter.
`timescale 1ns/1ps
`default_nettype none
module pacl_computer
  import pacl_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = STROBE_PERIOD_CYC,
  parameter int unsigned CAPACITY = COUNT_CAPACITY
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  pacl_if.computer_end link,
  output logic excitation_out,
  output logic dv_plus_out,
  output logic dv_minus_out,
  output logic [15:0] pulse_total_out
);
  localparam int unsigned SEL_START = SELECT_DELAY_CYC;
  localparam int unsigned DAT_START = SELECT_DELAY_CYC + DATA_DELAY_CYC;
  localparam int unsigned PHASE_OFS = (PERIOD_CYC * 135) / 360;

  logic [15:0] phase_cnt;
  logic signed [15:0] vel_cnt;

  // Period too short for the strobe train, or capacity under three, cannot work.
  if (PERIOD_CYC < DAT_START + DATA_WIDTH_CYC + 1 || PERIOD_CYC > 65535) begin : g_bad_period
    $error("PERIOD_CYC out of range");
  end
  if (CAPACITY < 3 || CAPACITY > 16000) begin : g_bad_capacity
    $error("CAPACITY out of range");
  end

  // Free running phase counter; the excitation and every strobe derive from it.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      phase_cnt <= 16'h0000;
    end else if (phase_cnt == 16'(PERIOD_CYC - 1)) begin
      phase_cnt <= 16'h0000;
    end else begin
      phase_cnt <= phase_cnt + 16'h0001;
    end
  end

  // Strobes from flip-flops; the sample sits 135 degrees after the rising crossing.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      excitation_out <= 1'b0;
      link.float_sample_strobe <= 1'b0;
      link.select_strobe <= 1'b0;
      link.data_strobe <= 1'b0;
    end else begin
      // One extra bit keeps the phase sum from wrapping on long periods.
      excitation_out <= ((17'(phase_cnt) + 17'(PHASE_OFS)) % 17'(PERIOD_CYC)) < 17'(PERIOD_CYC / 2);
      link.float_sample_strobe <= phase_cnt < 16'(SAMPLE_WIDTH_CYC);
      link.select_strobe <= phase_cnt >= 16'(SEL_START) &&
                            phase_cnt < 16'(SEL_START + SELECT_WIDTH_CYC);
      link.data_strobe <= phase_cnt >= 16'(DAT_START) &&
                          phase_cnt < 16'(DAT_START + DATA_WIDTH_CYC);
    end
  end

  // Up-down counter; each velocity pulse spans several cycles so count its rising edge.
  logic plus_d;
  logic minus_d;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      plus_d <= 1'b0;
      minus_d <= 1'b0;
      vel_cnt <= 16'sh0000;
      dv_plus_out <= 1'b0;
      dv_minus_out <= 1'b0;
      pulse_total_out <= 16'h0000;
    end else begin
      plus_d <= link.vel_plus_pulse;
      minus_d <= link.vel_minus_pulse;
      dv_plus_out <= 1'b0;
      dv_minus_out <= 1'b0;
      if (link.vel_plus_pulse && !plus_d) begin
        pulse_total_out <= pulse_total_out + 16'h0001;
        if (vel_cnt == 16'(signed'(CAPACITY))) begin
          vel_cnt <= 16'sh0000;
          dv_plus_out <= 1'b1;
        end else begin
          vel_cnt <= vel_cnt + 16'sh0001;
        end
      end else if (link.vel_minus_pulse && !minus_d) begin
        pulse_total_out <= pulse_total_out + 16'h0001;
        if (vel_cnt == -16'(signed'(CAPACITY))) begin
          vel_cnt <= 16'sh0000;
          dv_minus_out <= 1'b1;
        end else begin
          vel_cnt <= vel_cnt - 16'sh0001;
        end
      end
    end
  end
endmodule : pacl_computer
`default_nettype wire

/* File: tb/pacl_link_sva.sv */
// Checker of strobe timing and velocity gating on the loop link.
`timescale 1ns/1ps
`default_nettype none
module pacl_link_sva #(
  parameter int unsigned PERIOD_CYC = pacl_pkg::STROBE_PERIOD_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic float_sample_strobe,
  input wire logic select_strobe,
  input wire logic data_strobe,
  input wire logic vel_plus_pulse,
  input wire logic vel_minus_pulse
);
  logic prev_s;
  logic seen;
  logic [15:0] cnt;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Cycles since the sampling strobe rose; the first rise after reset only arms the period check.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      prev_s <= 1'b0;
      seen <= 1'b0;
      cnt <= 16'h0;
    end else begin
      prev_s <= float_sample_strobe;
      seen <= seen | float_sample_strobe;
      cnt <= (float_sample_strobe && !prev_s) ? 16'h1 : cnt + 16'h1;
    end
  end
  // Strobe edges are tied to the counter, so a width or spacing that slips by one cycle fails.
  chk_vel_one_hot: assert property (data_strobe |-> vel_plus_pulse ^ vel_minus_pulse)
    else $error("velocity pulses not one-hot");
  chk_vel_quiet: assert property (!data_strobe |-> !vel_plus_pulse && !vel_minus_pulse)
    else $error("velocity pulse outside data strobe");
  chk_vel_steady: assert property (data_strobe && $past(data_strobe) |-> $stable(vel_plus_pulse))
    else $error("winding changed during data strobe");
  chk_sample_width: assert property ($fell(float_sample_strobe) |-> cnt == 16'h00fa)
    else $error("sample strobe width wrong");
  chk_strobe_period: assert property ($rose(float_sample_strobe) && seen |-> cnt == 16'(PERIOD_CYC))
    else $error("strobe period wrong");
  chk_select_delay: assert property ($rose(select_strobe) |-> cnt == 16'h0177)
    else $error("select strobe delay wrong");
  chk_select_width: assert property ($fell(select_strobe) |-> cnt == 16'h02ee)
    else $error("select strobe width wrong");
  chk_data_delay: assert property ($rose(data_strobe) |-> cnt == 16'h0271)
    else $error("data strobe delay wrong");
  chk_data_width: assert property ($fell(data_strobe) |-> cnt == 16'h03e8)
    else $error("data strobe width wrong");
endmodule : pacl_link_sva
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench joining the loop end and the computer end across the link.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned PER = 1200;
  localparam int CAP = 4;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic zero_phase_in = 1'b1;
  logic pi_phase_in = 1'b0;
  logic psel, msel, tpl, tmi, dir, dvp, dvm;
  logic [15:0] total;
  logic [2:0] strb;
  logic exc;
  logic exc_prev;
  logic [15:0] exc_age;
  int n_mismatch = 0;
  int n_compared = 0;
  int net = 0;
  int n_dvp = 0;
  int n_dvm = 0;
  int exp_dvp = 0;
  int exp_dvm = 0;
  // Rows: zero phase, pi phase, direction expected; 3-3 cycles, alternation, hold cases, imbalance.
  logic [2:0] rows [32] = '{3'h5, 3'h5, 3'h5, 3'h2, 3'h2, 3'h2, 3'h5, 3'h5, 3'h5, 3'h2, 3'h2, 3'h2,
    3'h5, 3'h2, 3'h5, 3'h2, 3'h5, 3'h2, 3'h5, 3'h5, 3'h5, 3'h5, 3'h5, 3'h7, 3'h1,
    3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2};
  pacl_if u_pacl_if ();
  pacl_loop u_pacl_loop (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .link(u_pacl_if),
    .zero_phase_in(zero_phase_in), .pi_phase_in(pi_phase_in), .plus_select_pulse_out(psel),
    .minus_select_pulse_out(msel), .torque_plus_en_out(tpl), .torque_minus_en_out(tmi), .float_dir_out(dir));
  pacl_computer #(.PERIOD_CYC(PER), .CAPACITY(CAP)) u_pacl_computer (.clk_sys_in(clk_sys_in),
    .rst_in(rst_in), .link(u_pacl_if), .excitation_out(exc), .dv_plus_out(dvp), .dv_minus_out(dvm),
    .pulse_total_out(total));
  pacl_link_sva #(.PERIOD_CYC(PER)) u_pacl_link_sva (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .float_sample_strobe(u_pacl_if.float_sample_strobe), .select_strobe(u_pacl_if.select_strobe),
    .data_strobe(u_pacl_if.data_strobe), .vel_plus_pulse(u_pacl_if.vel_plus_pulse),
    .vel_minus_pulse(u_pacl_if.vel_minus_pulse));
  assign strb = {u_pacl_if.data_strobe, u_pacl_if.select_strobe, u_pacl_if.float_sample_strobe};
  initial forever #4 clk_sys_in = ~clk_sys_in;
  // Cycles since the excitation last rose; read at the falling edge, where it is settled.
  always_ff @(posedge clk_sys_in) begin
    exc_prev <= exc;
    exc_age <= (exc && !exc_prev) ? 16'h0001 : exc_age + 16'h0001;
  end
  // Count increments at the falling edge, clear of the edge that launches them.
  always @(negedge clk_sys_in) begin
    if (dvp === 1'b1) n_dvp++;
    if (dvm === 1'b1) n_dvm++;
  end
  task automatic cmp_bit(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_word(input string name, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask : cmp_word
  task automatic final_report();
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // A strobe that never arrives counts as a mismatch rather than hanging.
  task automatic wait_strb(input int w, input logic lvl);
    for (int i = 0; i < 2 * PER; i++) begin
      @(negedge clk_sys_in);
      if (strb[w] === lvl) return;
    end
    n_mismatch++;
    final_report();
  endtask : wait_strb
  // One period; phases flip between strobes to prove that they are ignored there.
  task automatic step(input logic [2:0] r, input bit chk_exc);
    zero_phase_in = r[2];
    pi_phase_in = r[1];
    wait_strb(0, 1'b1);
    if (chk_exc) cmp_word("exc_phase", 16'(PER * 135 / 360), exc_age);
    wait_strb(0, 1'b0);
    zero_phase_in = r[1];
    pi_phase_in = r[2];
    wait_strb(1, 1'b1);
    cmp_bit("dir", r[0], dir);
    cmp_bit("plus_sel", r[0], psel);
    cmp_bit("minus_sel", !r[0], msel);
    wait_strb(2, 1'b1);
    cmp_bit("torque_plus", r[0], tpl);
    cmp_bit("torque_minus", !r[0], tmi);
    cmp_bit("vel_plus", r[0], u_pacl_if.vel_plus_pulse);
    cmp_bit("vel_minus", !r[0], u_pacl_if.vel_minus_pulse);
    if (r[0] && net == CAP) begin
      exp_dvp++;
      net = 0;
    end else if (!r[0] && net == -CAP) begin
      exp_dvm++;
      net = 0;
    end else begin
      net += r[0] ? 1 : -1;
    end
    wait_strb(2, 1'b0);
  endtask : step
  // Table pass, then a reset half a cycle after a select strobe rises.
  initial begin
    repeat (6) @(negedge clk_sys_in);
    rst_in = 1'b0;
    for (int k = 0; k < 32; k++) step(rows[k], k > 0);
    cmp_word("total", 16'h0020, total);
    cmp_word("dv_plus", 16'(exp_dvp), 16'(n_dvp));
    cmp_word("dv_minus", 16'(exp_dvm), 16'(n_dvm));
    $display("Test table rows done");
    // Hold the loop at minus first, so that the reset values differ from what would run on.
    zero_phase_in = 1'b0;
    pi_phase_in = 1'b1;
    wait_strb(1, 1'b1);
    cmp_bit("dir_pre_rst", 1'b0, dir);
    rst_in = 1'b1;
    @(negedge clk_sys_in);
    cmp_bit("dir_rst", pacl_pkg::DIR_RESET, dir);
    cmp_bit("torque_plus_rst", 1'b1, tpl);
    cmp_bit("torque_minus_rst", 1'b0, tmi);
    cmp_word("total_rst", 16'h0000, total);
    rst_in = 1'b0;
    step(3'h2, 1'b0);
    cmp_word("total_after_rst", 16'h0001, total);
    $display("Test mid-run reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
